// ### src/cpt_aux_seq.sv
// auxiliary converter sequencer: reset, discard and oversample phases per channel
`timescale 1ns/1ns
module cpt_aux_seq (
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire logic                 modTick,
    input  wire cpt_pkg::cpt_aux_cfg_t cfg,
    input  wire logic                 startReq,
    output logic                      convBusy,
    output logic [1:0]                convChan,
    output logic                      convDone
);
    typedef struct packed {
        cpt_pkg::cpt_aux_phase_t phase;
        logic [10:0]             cnt;
        logic [1:0]              chan;
        logic                    busy;
        logic                    done;
    } cpt_seq_state_t;

    cpt_seq_state_t s_r;
    cpt_seq_state_t s_nxt;
    logic           seqMode;
    logic           multiMode;

    assign seqMode   = cfg.mode[1];
    assign multiMode = cfg.mode[0];

    // phase walk, counted in modulator ticks
    always_comb begin
        s_nxt      = s_r;
        s_nxt.done = 1'b0;
        unique case (s_r.phase)
            cpt_pkg::AUX_IDLE: begin
                if (cfg.enable && (startReq || (seqMode && !cfg.stop))) begin // [R22]
                    s_nxt.phase = cpt_pkg::AUX_RESET;
                    s_nxt.cnt   = 11'(cpt_pkg::reset_clks(cfg.resetLengthSel) - 11'h001); // [R3]
                    s_nxt.chan  = 2'h0;
                end
            end
            cpt_pkg::AUX_RESET: begin
                if (modTick && s_r.cnt == 11'h000) begin
                    s_nxt.phase = cpt_pkg::AUX_DISCARD;
                    s_nxt.cnt = 11'(cpt_pkg::discard_clks(cfg.discardCountSel) - 11'h001); // [R2]
                end else if (modTick) begin
                    s_nxt.cnt = s_r.cnt - 11'h001;
                end
            end
            cpt_pkg::AUX_DISCARD: begin
                if (modTick && s_r.cnt == 11'h000) begin
                    s_nxt.phase = cpt_pkg::AUX_CONVERT;
                    s_nxt.cnt   = 11'(cpt_pkg::osr_clks(cfg.oversampleSel) - 11'h001); // [R4]
                end else if (modTick) begin
                    s_nxt.cnt = s_r.cnt - 11'h001;
                end
            end
            cpt_pkg::AUX_CONVERT: begin
                if (modTick && s_r.cnt == 11'h000) begin
                    s_nxt.phase = cpt_pkg::AUX_RESET;
                    s_nxt.cnt   = 11'(cpt_pkg::reset_clks(cfg.resetLengthSel) - 11'h001);
                    if (multiMode && s_r.chan != cpt_pkg::AUX_LAST_CH) begin // [R22]
                        s_nxt.chan = s_r.chan + 2'h1;
                    end else if (seqMode && !cfg.stop) begin
                        s_nxt.chan = 2'h0; // sequential modes wrap around
                    end else begin
                        s_nxt.phase = cpt_pkg::AUX_IDLE;
                        s_nxt.done  = !seqMode;
                    end
                end else if (modTick) begin
                    s_nxt.cnt = s_r.cnt - 11'h001;
                end
            end
        endcase
        // disabling aborts any conversion at once
        if (!cfg.enable) begin
            s_nxt.phase = cpt_pkg::AUX_IDLE;
        end
        s_nxt.busy = (s_nxt.phase != cpt_pkg::AUX_IDLE);
    end

    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '{phase: cpt_pkg::AUX_IDLE, cnt: 11'h000, chan: 2'h0, busy: 1'b0,
                     done: 1'b0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign convBusy = s_r.busy;
    assign convChan = s_r.chan;
    assign convDone = s_r.done;

    // entry into each phase loads the selected length
    sequence enter_reset_s;
        (s_r.phase != cpt_pkg::AUX_RESET) ##1 (s_r.phase == cpt_pkg::AUX_RESET);
    endsequence
    sequence enter_discard_s;
        (s_r.phase == cpt_pkg::AUX_RESET) ##1 (s_r.phase == cpt_pkg::AUX_DISCARD);
    endsequence
    sequence enter_convert_s;
        (s_r.phase == cpt_pkg::AUX_DISCARD) ##1 (s_r.phase == cpt_pkg::AUX_CONVERT);
    endsequence

    reset_length_a: assert property (@(posedge clk) disable iff (!rst_n) // [R3]
        enter_reset_s |-> s_r.cnt == 11'(cpt_pkg::reset_clks(cfg.resetLengthSel) - 11'h001))
        else $error("reset phase loaded wrong length");
    discard_length_a: assert property (@(posedge clk) disable iff (!rst_n) // [R2]
        enter_discard_s |-> s_r.cnt == 11'(cpt_pkg::discard_clks(cfg.discardCountSel) - 11'h001))
        else $error("discard phase loaded wrong length");
    oversample_length_a: assert property (@(posedge clk) disable iff (!rst_n) // [R4]
        enter_convert_s |-> s_r.cnt == 11'(cpt_pkg::osr_clks(cfg.oversampleSel) - 11'h001))
        else $error("convert phase loaded wrong ratio");
endmodule // cpt_aux_seq

// ### src/cpt_pkg.sv
// constants, field layouts and carrier types of the codec power-tune / input-config bank
package cpt_pkg;

    // clock and modulator-rate divider
    localparam int       CLK_HZ      = 20_000_000;
    localparam int       MOD_CLK_HZ  = 3_000_000;
    localparam int       MOD_DIV_INT = CLK_HZ / MOD_CLK_HZ; // rounds down: tick slightly fast
    localparam logic [2:0] MOD_DIV_LAST = 3'(MOD_DIV_INT - 1);

    // register offsets
    localparam logic [7:0] ADDR_AUX_TIMING = 8'h4C;
    localparam logic [7:0] ADDR_REC_TUNE   = 8'h4E;
    localparam logic [7:0] ADDR_PB_TUNE    = 8'h4F;
    localparam logic [7:0] ADDR_CH1_INPUT  = 8'h50;
    localparam logic [7:0] ADDR_AUX_CTRL   = 8'h51;

    // reset values
    localparam logic [7:0] RST_AUX_TIMING = 8'h5C;
    localparam logic [7:0] RST_REC_TUNE   = 8'h00;
    localparam logic [7:0] RST_PB_TUNE    = 8'h00;
    localparam logic [7:0] RST_CH1_INPUT  = 8'h00;
    localparam logic [7:0] RST_AUX_CTRL   = 8'h00;

    // writable bits; read-only reserved bits keep their reset value
    localparam logic [7:0] WMASK_AUX_TIMING = 8'hFC;
    localparam logic [7:0] WMASK_REC_TUNE   = 8'hFC;
    localparam logic [7:0] WMASK_PB_TUNE    = 8'hFE;
    localparam logic [7:0] WMASK_CH1_INPUT  = 8'hFF;
    localparam logic [7:0] WMASK_AUX_CTRL   = 8'hF8;

    // field positions
    localparam int AT_DISCARD_LSB = 6;
    localparam int AT_RESET_LSB   = 4;
    localparam int AT_OSR_LSB     = 2;
    localparam int RT_MODCLK      = 7;
    localparam int RT_COMB        = 6;
    localparam int RT_FIR         = 5;
    localparam int RT_LOWPWR      = 2;
    localparam int PT_MODCLK      = 7;
    localparam int PT_FIRSEG      = 5;
    localparam int PT_LOWPWR      = 2;
    localparam int PT_IREF        = 1;
    localparam int CH_SRC_LSB     = 6;
    localparam int CH_IMP_LSB     = 4;
    localparam int CH_CM_LSB      = 2;
    localparam int CH_FS          = 1;
    localparam int CH_BW          = 0;
    localparam int AC_EN          = 7;
    localparam int AC_MODE_LSB    = 5;
    localparam int AC_START       = 4;
    localparam int AC_STOP        = 3;
    localparam int AC_DONE        = 2;

    // channels visited by the multi-channel modes
    localparam logic [1:0] AUX_LAST_CH = 2'h3;

    // auxiliary converter modes
    localparam logic [1:0] MODE_ONESHOT_SINGLE = 2'h0;
    localparam logic [1:0] MODE_ONESHOT_MULTI  = 2'h1;
    localparam logic [1:0] MODE_SEQ_SINGLE     = 2'h2;
    localparam logic [1:0] MODE_SEQ_MULTI      = 2'h3;

    typedef enum logic [1:0] {
        AUX_IDLE    = 2'h0,
        AUX_RESET   = 2'h1,
        AUX_DISCARD = 2'h3,
        AUX_CONVERT = 2'h2
    } cpt_aux_phase_t;

    typedef struct packed {
        logic       modclkHalve;
        logic       combOrder;
        logic       firSkip;
        logic       lowpowerFilterEn;
    } cpt_rec_cfg_t;

    typedef struct packed {
        logic       modclkHalve;
        logic       firSegmenterSkip;
        logic       lowpowerFilterEn;
        logic       refcurrentHalve;
    } cpt_pb_cfg_t;

    typedef struct packed {
        logic [1:0] inputSource;
        logic [1:0] inputImpedance;
        logic [1:0] commonModeTolerance;
        logic       fullScaleSelect;
        logic       bandwidthSelect;
    } cpt_ch1_cfg_t;

    typedef struct packed {
        logic [1:0] discardCountSel;
        logic [1:0] resetLengthSel;
        logic [1:0] oversampleSel;
        logic       enable;
        logic [1:0] mode;
        logic       stop;
    } cpt_aux_cfg_t;

    // modulator clocks discarded after start, per code
    function automatic logic [10:0] discard_clks(input logic [1:0] sel);
        unique case (sel)
            2'h0: discard_clks = 11'h180;
            2'h1: discard_clks = 11'h240;
            2'h2: discard_clks = 11'h380;
            2'h3: discard_clks = 11'h400;
        endcase
    endfunction

    // modulator clocks of converter reset, per code
    function automatic logic [10:0] reset_clks(input logic [1:0] sel);
        unique case (sel)
            2'h0: reset_clks = 11'h032;
            2'h1: reset_clks = 11'h04B;
            2'h2: reset_clks = 11'h064;
            2'h3: reset_clks = 11'h096;
        endcase
    endfunction

    // oversampling ratio, per code
    function automatic logic [10:0] osr_clks(input logic [1:0] sel);
        unique case (sel)
            2'h0: osr_clks = 11'h020;
            2'h1: osr_clks = 11'h040;
            2'h2: osr_clks = 11'h060;
            2'h3: osr_clks = 11'h080;
        endcase
    endfunction

endpackage

// ### src/cpt_regbank.sv
// codec power-tune, record input and auxiliary converter register bank
// Function
// (R1) timing register at 0x4C, resets to 0x5C
// (R2) timing bits 7-6 pick discarded clocks: 384, 576, 896, 1024
// (R3) timing bits 5-4 pick converter reset length: 50, 75, 100, 150 clocks
// (R4) timing bits 3-2 pick oversampling ratio: 32, 64, 96, 128
// (R5) software writes reset values to reserved fields; read-only ones ignore writes
// (R6) record tuning register at 0x4E, resets to 0x00
// (R7) record bit 7 halves modulator clock from 3 MHz to 1.5 MHz; here the tick is 20 MHz / 6, so about 3.33 to 1.67 MHz
// (R8) record bit 6 picks comb order: 0 fifth, 1 fourth
// (R9) record bit 5 set bypasses the record FIR stage
// (R10) record bit 2 enables the record low-power filter
// (R11) playback tuning register at 0x4F, resets to 0x00
// (R12) playback bit 7 halves playback modulator clock
// (R13) playback bit 5 bypasses FIR and segmenter together
// (R14) playback bit 2 enables the playback low-power filter
// (R15) playback bit 1 halves the reference current
// (R16) channel 1 input register at 0x50, resets to 0x00
// (R17) channel 1 bits 7-6 select input source
// (R18) channel 1 bits 5-4 set input impedance; code 3 reserved
// (R19) channel 1 bits 3-2 set coupling and common-mode tolerance; code 3 reserved
// (R20) software sets 4 Vrms full scale only with its supporting settings
// (R21) bit 0 selects wide bandwidth; software uses it only at 40 kilo-ohm
// (R22) auxiliary control register holds enable and two-bit conversion mode
// (R23) writable fields hold the last written value until next write or reset
`timescale 1ns/1ns
module cpt_regbank (
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire logic                  regWrEn,
    input  wire logic                  regRdEn,
    input  wire logic [7:0]            regAddr,
    input  wire logic [7:0]            regWrData,
    output logic [7:0]                 regRdData,
    output logic                       regRdValid,
    output cpt_pkg::cpt_rec_cfg_t      recCfg,
    output cpt_pkg::cpt_pb_cfg_t       pbCfg,
    output cpt_pkg::cpt_ch1_cfg_t      ch1Cfg,
    output cpt_pkg::cpt_aux_cfg_t      auxCfg,
    output logic                       recModTick,
    output logic                       auxConvBusy,
    output logic [1:0]                 auxConvChan
);
    typedef struct packed {
        logic [7:0] auxTiming;
        logic [7:0] recTune;
        logic [7:0] pbTune;
        logic [7:0] ch1Input;
        logic [7:0] auxCtrl;
        logic       auxDone;
        logic       startPulse;
        logic [7:0] rdData;
        logic       rdValid;
        logic [2:0] divCnt;
        logic       halfPhase;
        logic       modTick;
    } cpt_bank_state_t;

    cpt_bank_state_t s_r;
    cpt_bank_state_t s_nxt;
    logic            convDone;

    // merge a write into a register, keeping read-only bits
    function automatic logic [7:0] merge_wr(input logic [7:0] cur, input logic [7:0] wd,
                                            input logic [7:0] mask);
        merge_wr = (cur & ~mask) | (wd & mask);
    endfunction

    // read multiplexer; unmapped offsets read as zero
    function automatic logic [7:0] read_mux(input logic [7:0] addr,
                                            input cpt_bank_state_t st);
        unique case (addr)
            cpt_pkg::ADDR_AUX_TIMING: read_mux = st.auxTiming;
            cpt_pkg::ADDR_REC_TUNE:   read_mux = st.recTune;
            cpt_pkg::ADDR_PB_TUNE:    read_mux = st.pbTune;
            cpt_pkg::ADDR_CH1_INPUT:  read_mux = st.ch1Input;
            cpt_pkg::ADDR_AUX_CTRL: begin
                read_mux = st.auxCtrl;
                read_mux[cpt_pkg::AC_DONE] = st.auxDone;
            end
            default:                  read_mux = 8'h00;
        endcase
    endfunction

    // next-state logic: divider, register writes, read answer
    always_comb begin
        s_nxt            = s_r;
        s_nxt.rdValid    = 1'b0;
        s_nxt.startPulse = 1'b0;
        s_nxt.modTick    = 1'b0;
        // modulator tick, every second one when the record clock is halved
        if (s_r.divCnt == cpt_pkg::MOD_DIV_LAST) begin
            s_nxt.divCnt    = 3'h0;
            s_nxt.halfPhase = ~s_r.halfPhase;
            s_nxt.modTick   = ~s_r.recTune[cpt_pkg::RT_MODCLK] | s_r.halfPhase; // [R7]
        end else begin
            s_nxt.divCnt = s_r.divCnt + 3'h1;
        end
        // register writes; read-only reserved bits are masked off
        if (regWrEn) begin
            unique case (regAddr)
                cpt_pkg::ADDR_AUX_TIMING: s_nxt.auxTiming = merge_wr(s_r.auxTiming,
                    regWrData, cpt_pkg::WMASK_AUX_TIMING); // [R1] [R5] [R23]
                cpt_pkg::ADDR_REC_TUNE:   s_nxt.recTune = merge_wr(s_r.recTune,
                    regWrData, cpt_pkg::WMASK_REC_TUNE); // [R6] [R5] [R23]
                cpt_pkg::ADDR_PB_TUNE:    s_nxt.pbTune = merge_wr(s_r.pbTune,
                    regWrData, cpt_pkg::WMASK_PB_TUNE); // [R11] [R5] [R23]
                cpt_pkg::ADDR_CH1_INPUT:  s_nxt.ch1Input = merge_wr(s_r.ch1Input,
                    regWrData, cpt_pkg::WMASK_CH1_INPUT); // [R16] [R23]
                cpt_pkg::ADDR_AUX_CTRL: begin
                    s_nxt.auxCtrl = merge_wr(s_r.auxCtrl, regWrData,
                                             cpt_pkg::WMASK_AUX_CTRL); // [R22] [R23]
                    s_nxt.startPulse = regWrData[cpt_pkg::AC_START]
                                     & regWrData[cpt_pkg::AC_EN];
                end
                default: ;
            endcase
        end
        // done flag: a new start clears it, a finished one-shot conversion sets it and wins
        if (s_nxt.startPulse) begin
            s_nxt.auxDone = 1'b0;
        end
        if (convDone) begin
            s_nxt.auxDone = 1'b1;
        end
        // read answer one cycle after the strobe
        if (regRdEn) begin
            s_nxt.rdData  = read_mux(regAddr, s_r);
            s_nxt.rdValid = 1'b1;
        end
    end

    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '{auxTiming: cpt_pkg::RST_AUX_TIMING, recTune: cpt_pkg::RST_REC_TUNE,
                     pbTune: cpt_pkg::RST_PB_TUNE, ch1Input: cpt_pkg::RST_CH1_INPUT,
                     auxCtrl: cpt_pkg::RST_AUX_CTRL, auxDone: 1'b0, startPulse: 1'b0,
                     rdData: 8'h00, rdValid: 1'b0, divCnt: 3'h0, halfPhase: 1'b0,
                     modTick: 1'b0}; // [R1] [R6] [R11] [R16]
        end else begin
            s_r <= s_nxt;
        end
    end

    // record path controls
    assign recCfg.modclkHalve      = s_r.recTune[cpt_pkg::RT_MODCLK];  // [R7]
    assign recCfg.combOrder        = s_r.recTune[cpt_pkg::RT_COMB];    // [R8]
    assign recCfg.firSkip          = s_r.recTune[cpt_pkg::RT_FIR];     // [R9]
    assign recCfg.lowpowerFilterEn = s_r.recTune[cpt_pkg::RT_LOWPWR];  // [R10]

    // playback path controls
    assign pbCfg.modclkHalve       = s_r.pbTune[cpt_pkg::PT_MODCLK];   // [R12]
    assign pbCfg.firSegmenterSkip  = s_r.pbTune[cpt_pkg::PT_FIRSEG];   // [R13]
    assign pbCfg.lowpowerFilterEn  = s_r.pbTune[cpt_pkg::PT_LOWPWR];   // [R14]
    assign pbCfg.refcurrentHalve   = s_r.pbTune[cpt_pkg::PT_IREF];     // [R15]

    // channel 1 input setup
    assign ch1Cfg.inputSource         = s_r.ch1Input[cpt_pkg::CH_SRC_LSB +: 2]; // [R17]
    assign ch1Cfg.inputImpedance      = s_r.ch1Input[cpt_pkg::CH_IMP_LSB +: 2]; // [R18]
    assign ch1Cfg.commonModeTolerance = s_r.ch1Input[cpt_pkg::CH_CM_LSB +: 2];  // [R19]
    assign ch1Cfg.fullScaleSelect     = s_r.ch1Input[cpt_pkg::CH_FS];
    assign ch1Cfg.bandwidthSelect     = s_r.ch1Input[cpt_pkg::CH_BW];

    // auxiliary converter settings
    assign auxCfg.discardCountSel = s_r.auxTiming[cpt_pkg::AT_DISCARD_LSB +: 2]; // [R2]
    assign auxCfg.resetLengthSel  = s_r.auxTiming[cpt_pkg::AT_RESET_LSB +: 2];   // [R3]
    assign auxCfg.oversampleSel   = s_r.auxTiming[cpt_pkg::AT_OSR_LSB +: 2];     // [R4]
    assign auxCfg.enable          = s_r.auxCtrl[cpt_pkg::AC_EN];                 // [R22]
    assign auxCfg.mode            = s_r.auxCtrl[cpt_pkg::AC_MODE_LSB +: 2];      // [R22]
    assign auxCfg.stop            = s_r.auxCtrl[cpt_pkg::AC_STOP];

    assign regRdData  = s_r.rdData;
    assign regRdValid = s_r.rdValid;
    assign recModTick = s_r.modTick;

    // auxiliary converter sequencer
    cpt_aux_seq u_aux_seq (
        .clk      (clk),
        .rst_n    (rst_n),
        .modTick  (s_r.modTick),
        .cfg      (auxCfg),
        .startReq (s_r.startPulse),
        .convBusy (auxConvBusy),
        .convChan (auxConvChan),
        .convDone (convDone)
    );

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence wr_s(logic [7:0] a);
        regWrEn && regAddr == a;
    endsequence
    sequence rd_s(logic [7:0] a);
        regRdEn && regAddr == a;
    endsequence

    timing_reset_a: assert property ($rose(rst_n) |-> s_r.auxTiming == cpt_pkg::RST_AUX_TIMING) // [R1]
        else $error("timing register not at reset value");
    timing_resv_a: assert property (rd_s(cpt_pkg::ADDR_AUX_TIMING) |=> // [R1]
        regRdValid && regRdData[1:0] == 2'h0 && regRdData[7:2] == $past(s_r.auxTiming[7:2]))
        else $error("timing read back wrong");
    rec_write_a: assert property (wr_s(cpt_pkg::ADDR_REC_TUNE) |=> // [R9]
        recCfg.firSkip == $past(regWrData[5]) && recCfg.combOrder == $past(regWrData[6])
        && s_r.recTune[1:0] == 2'h0) else $error("record tuning write not applied");
    pb_write_a: assert property (wr_s(cpt_pkg::ADDR_PB_TUNE) |=> // [R13]
        pbCfg.firSegmenterSkip == $past(regWrData[5]) && pbCfg.refcurrentHalve ==
        $past(regWrData[1]) && s_r.pbTune[0] == 1'b0) else $error("playback write wrong");
    ch1_write_a: assert property (wr_s(cpt_pkg::ADDR_CH1_INPUT) |=> // [R17]
        ch1Cfg == $past(regWrData)) else $error("channel 1 write not applied");
    ch1_hold_a: assert property (!(regWrEn && regAddr == cpt_pkg::ADDR_CH1_INPUT) // [R23]
        |=> $stable(ch1Cfg)) else $error("channel 1 setting changed without write");
    aux_ctrl_a: assert property (wr_s(cpt_pkg::ADDR_AUX_CTRL) |=> // [R22]
        auxCfg.enable == $past(regWrData[7]) && auxCfg.mode == $past(regWrData[6:5]))
        else $error("auxiliary control write not applied");
    unmapped_read_a: assert property (regRdEn && regAddr == 8'h4D |=> // [R6]
        regRdValid && regRdData == 8'h00) else $error("unmapped offset read non-zero");
    tick_full_a: assert property (recModTick && !recCfg.modclkHalve && // [R7]
        $stable(recCfg.modclkHalve) |=> !recModTick [*5] ##1 (recModTick || recCfg.modclkHalve))
        else $error("modulator tick spacing wrong");
endmodule // cpt_regbank

// ### verification/cpt_host.sv
// host model that drives the bank's register strobe port
`timescale 1ns/1ns
module cpt_host (
    input  wire logic       clk,
    output logic            regWrEn,
    output logic            regRdEn,
    output logic [7:0]      regAddr,
    output logic [7:0]      regWrData,
    input  wire logic [7:0] regRdData,
    input  wire logic       regRdValid
);
    // idle strobes from time zero
    initial begin
        regWrEn = 1'b0;
        regRdEn = 1'b0;
        regAddr = 8'h00;
        regWrData = 8'h00;
    end
    // one-cycle write strobe; data is scrambled once the strobe drops
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        regWrEn <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clk);
        regWrEn <= 1'b0;
        regWrData <= ~d;
    endtask
    // one-cycle read strobe, then a bounded wait for the valid pulse
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
        ok = 1'b0;
        d = 8'h00;
        @(posedge clk);
        regRdEn <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRdEn <= 1'b0;
        for (int i = 0; i < 4 && !ok; i++) begin
            #1;
            if (regRdValid === 1'b1) begin
                ok = 1'b1;
                d = regRdData;
            end else @(posedge clk);
        end
    endtask
endmodule // cpt_host

// ### verification/cpt_regbank_test.sv
// self-checking bench of the power-tune and input-config register bank
`timescale 1ns/1ns
module cpt_regbank_test;
    logic                  clk = 1'b0;
    logic                  rst_n = 1'b0;
    logic                  regWrEn, regRdEn, regRdValid, recModTick, auxConvBusy, ok;
    logic [7:0]            regAddr, regWrData, regRdData, rv;
    logic [1:0]            auxConvChan, maxChan;
    cpt_pkg::cpt_rec_cfg_t recCfg;
    cpt_pkg::cpt_pb_cfg_t  pbCfg;
    cpt_pkg::cpt_ch1_cfg_t ch1Cfg;
    cpt_pkg::cpt_aux_cfg_t auxCfg;
    int                    errTotal = 0;
    int                    checksDone = 0;
    logic [7:0]            ad[5] = '{8'h4C, 8'h4E, 8'h4F, 8'h50, 8'h51};
    logic [7:0]            wv[5] = '{8'hFF, 8'hFF, 8'hFF, 8'hEA, 8'h6B};
    logic [7:0]            ev[5] = '{8'hFC, 8'hFC, 8'hFE, 8'hEA, 8'h68};
    logic [7:0]            cv[4] = '{8'h00, 8'h54, 8'hA9, 8'hEA};

    cpt_host host (.clk(clk), .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr),
        .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid));
    cpt_regbank dut (.clk(clk), .rst_n(rst_n), .regWrEn(regWrEn), .regRdEn(regRdEn),
        .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
        .regRdValid(regRdValid), .recCfg(recCfg), .pbCfg(pbCfg), .ch1Cfg(ch1Cfg),
        .auxCfg(auxCfg), .recModTick(recModTick), .auxConvBusy(auxConvBusy),
        .auxConvChan(auxConvChan));

    always #25 clk = ~clk;

    // compare and count
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checksDone++;
        if (g !== e) begin
            errTotal++;
            $display("wrong value %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic rdChk(input logic [7:0] a, input logic [7:0] e);
        host.rd(a, rv, ok);
        chk("read valid", 16'h1, {15'h0, ok});
        chk($sformatf("reg %h", a), {8'h0, e}, {8'h0, rv});
    endtask
    // cycles between two modulator ticks
    task automatic tickGap(input logic [15:0] e);
        int n;
        @(negedge clk); // align first, so a tick already standing is not counted twice
        for (n = 0; n < 30 && recModTick !== 1'b1; n++) @(negedge clk);
        for (n = 1; n < 30; n++) begin
            @(negedge clk);
            if (recModTick === 1'b1) break;
        end
        chk("tick gap", e, n[15:0]);
    endtask
    // start a conversion and time its busy window, one tick of slack each way
    task automatic runConv(input logic [7:0] ctl, input int e);
        int n;
        host.wr(8'h51, ctl);
        for (n = 0; n < 8 && auxConvBusy !== 1'b1; n++) @(negedge clk);
        maxChan = 2'h0;
        for (n = 0; n < 40000 && auxConvBusy === 1'b1; n++) begin
            @(negedge clk);
            if (auxConvChan > maxChan) maxChan = auxConvChan;
        end
        chk("busy length", 16'h1, {15'h0, (n >= e - 6 && n <= e + 6)});
    endtask
    task automatic finishTest();
        $display("checks %0d mismatches %0d", checksDone, errTotal);
        if (errTotal == 0 && checksDone > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // watchdog against a hang
    initial begin
        #5000000;
        errTotal++;
        finishTest();
    end

    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 5; i++) rdChk(ad[i], i == 0 ? 8'h5C : 8'h00);
        rdChk(8'h4D, 8'h00);
        chk("aux reset fields", 16'h170, {6'h0, auxCfg});
        $display("test reset values done");
        for (int i = 0; i < 5; i++) host.wr(ad[i], wv[i]);
        host.wr(8'h4D, 8'hFF);
        for (int i = 0; i < 5; i++) rdChk(ad[i], ev[i]);
        chk("record cfg", 16'hF, {12'h0, recCfg});
        chk("playback cfg", 16'hF, {12'h0, pbCfg});
        chk("aux cfg", 16'h3F7, {6'h0, auxCfg});
        tickGap(16'd12);
        host.wr(8'h4E, 8'h44);
        host.wr(8'h4F, 8'h82);
        rdChk(8'h4E, 8'h44);
        rdChk(8'h4F, 8'h82);
        chk("record cfg", 16'h5, {12'h0, recCfg});
        chk("playback cfg", 16'h9, {12'h0, pbCfg});
        tickGap(16'd6);
        $display("test masks and fields done");
        for (int i = 0; i < 4; i++) begin
            host.wr(8'h4C, {i[1:0], i[1:0], i[1:0], 2'b00});
            host.wr(8'h50, cv[i]);
            @(negedge clk);
            chk("aux codes", {10'h0, {3{i[1:0]}}}, {10'h0, auxCfg[9:4]});
            chk("ch1 fields", {8'h0, cv[i]}, {8'h0, ch1Cfg});
        end
        $display("test field codes done");
        host.wr(8'h4C, 8'hFC);
        runConv(8'h90, 6 * (150 + 1024 + 128));
        rdChk(8'h51, 8'h94);
        host.wr(8'h4C, 8'h00);
        runConv(8'h90, 6 * (50 + 384 + 32));
        chk("single channel", 16'h0, {14'h0, maxChan});
        runConv(8'hB0, 4 * 6 * (50 + 384 + 32));
        chk("last channel", 16'h3, {14'h0, maxChan});
        host.wr(8'h51, 8'h90);
        repeat (20) @(negedge clk);
        chk("busy before abort", 16'h1, {15'h0, auxConvBusy});
        host.wr(8'h51, 8'h00);
        repeat (3) @(negedge clk);
        chk("busy after abort", 16'h0, {15'h0, auxConvBusy});
        rdChk(8'h51, 8'h00);
        // sequential modes start by themselves; stop lands one cycle into the run
        host.wr(8'h51, 8'hC0);
        runConv(8'hC8, 6 * (50 + 384 + 32) - 3);
        rdChk(8'h51, 8'hC8);
        host.wr(8'h51, 8'hE0);
        runConv(8'hE8, 4 * 6 * (50 + 384 + 32) - 3);
        chk("last channel", 16'h3, {14'h0, maxChan});
        rdChk(8'h51, 8'hE8);
        $display("test aux converter done");
        finishTest();
    end
endmodule // cpt_regbank_test
